// ### verilog/bcx_core.sv
// Implementation choices: the register offsets and the plain strobed port.
`include "bcx_params.svh"

module bcx_core #(
  parameter int FILE_DEPTH = 32
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // instruction from fetch
  input  wire bcx_pkg::bcx_instr_t instr,
  output logic                     instr_ready,
  // program counter control
  input  wire logic [10:0]         stack_top,
  output logic [10:0]              pc_value,
  output logic                     pc_load,
  output logic                     fetch_flush,
  // option register
  output logic [7:0]               option_value,
  output logic                     option_load,
  // watchdog and sleep
  output logic                     watchdog_counter_clr,
  output logic                     prescaler_clr,
  output logic                     osc_stop,
  input  wire logic                wake_req,
  // file register write mirror
  output logic                     file_wr_en,
  output logic [4:0]               file_wr_addr,
  output logic [7:0]               file_wr_data,
  // register bus
  input  wire bcx_pkg::bcx_bus_t   bus,
  output logic [7:0]               bus_rdata
);

  bcx_pkg::bcx_core_t s_reg;
  bcx_pkg::bcx_core_t s_next;

  logic [10:0] pc_reg;
  logic [10:0] pc_next;
  logic        fw_en_reg;
  logic        fw_en_next;
  logic [4:0]  fw_addr_reg;
  logic [4:0]  fw_addr_next;
  logic [7:0]  fw_data_reg;
  logic [7:0]  fw_data_next;

  // decode of the word on the fetch port
  logic        take;
  logic [7:0]  lit;
  logic [4:0]  faddr_in;
  logic        dest_in;
  logic        is_load_lit;
  logic        is_ret_lit;
  logic        is_opt_load;
  logic        is_sleep;
  logic        is_sub;
  logic        is_rot_left;
  logic        is_rot_right;

  // file operand and results of the second cycle
  logic [7:0]  fval;
  logic [8:0]  sub_sum;
  logic [4:0]  sub_low;
  logic [7:0]  res;
  logic        res_carry;

  // file write from core and bus
  logic        core_fwr;
  logic        bus_fwr;
  logic        mem_wr;
  logic [4:0]  mem_waddr;
  logic [7:0]  mem_wdata;
  logic [7:0]  status_view;
  logic [7:0]  core_view;

  // instruction fields
  assign take         = instr.valid && s_reg.ready;
  assign lit          = instr.word[`BCX_LIT_MSB:0];
  assign faddr_in     = instr.word[`BCX_FADDR_MSB:0];
  assign dest_in      = instr.word[`BCX_DEST_BIT];
  assign is_load_lit  = (instr.word & `BCX_MASK_LIT) == `BCX_ENC_LOAD_LIT;
  assign is_ret_lit   = (instr.word & `BCX_MASK_LIT) == `BCX_ENC_RET_LIT;
  assign is_opt_load  = (instr.word & `BCX_MASK_FULL) == `BCX_ENC_OPT_LOAD;
  assign is_sleep     = (instr.word & `BCX_MASK_FULL) == `BCX_ENC_SLEEP;
  assign is_sub       = (instr.word & `BCX_MASK_FILE) == `BCX_ENC_SUB;
  assign is_rot_left  = (instr.word & `BCX_MASK_FILE) == `BCX_ENC_ROT_LEFT;
  assign is_rot_right = (instr.word & `BCX_MASK_FILE) == `BCX_ENC_ROT_RIGHT;

  // file register storage, read address given in the accepting cycle
  bcx_file_mem #(
    .W (8),
    .D (FILE_DEPTH),
    .A (5)
  ) u_file (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (faddr_in),
    .rd_data (fval)
  );

  // subtract as f plus inverted accumulator plus one
  assign sub_sum = {1'b0, fval} + {1'b0, ~s_reg.acc} + 9'h001;
  assign sub_low = {1'b0, fval[3:0]} + {1'b0, ~s_reg.acc[3:0]} + 5'h01;

  // result and carry of the file operation in flight
  always_comb begin
    res       = sub_sum[7:0];
    res_carry = sub_sum[8];
    case (s_reg.alu)
      bcx_pkg::ALU_SUB: begin
        res       = sub_sum[7:0];
        res_carry = sub_sum[8];
      end
      bcx_pkg::ALU_RL: begin
        res       = {fval[6:0], s_reg.carry};
        res_carry = fval[7];
      end
      bcx_pkg::ALU_RR: begin
        res       = {s_reg.carry, fval[7:1]};
        res_carry = fval[0];
      end
      default: begin
        res       = fval;
        res_carry = s_reg.carry;
      end
    endcase
  end

  // the core wins the write port; a bus file write in that cycle is dropped
  assign core_fwr  = (s_reg.st == bcx_pkg::ST_FILE) && s_reg.dest_file;
  assign bus_fwr   = bus.wr && (bus.addr[5] == 1'(`BCX_OFF_FILE_BASE >> 5));
  assign mem_wr    = core_fwr || bus_fwr;
  assign mem_waddr = core_fwr ? s_reg.faddr : bus.addr[4:0];
  assign mem_wdata = core_fwr ? res : bus.wdata;

  // status and core views for the bus
  always_comb begin
    status_view                = 8'h00;
    status_view[`BCX_ST_CARRY] = s_reg.carry;
    status_view[`BCX_ST_HALF]  = s_reg.half;
    status_view[`BCX_ST_ZERO]  = s_reg.zero;
    status_view[`BCX_ST_PD_N]  = s_reg.pd_n;
    status_view[`BCX_ST_TO_N]  = s_reg.to_n;
    status_view[`BCX_ST_WAKE]  = s_reg.wake;
    core_view                  = {5'h00, s_reg.osc_stop, s_reg.st};
  end

  // sequencer, flags and bus; an instruction outranks a bus write of the
  // same register because software must not undo a completed operation
  always_comb begin
    s_next          = s_reg;
    pc_next         = pc_reg;
    fw_en_next      = 1'b0;
    fw_addr_next    = fw_addr_reg;
    fw_data_next    = fw_data_reg;
    s_next.pc_load  = 1'b0;
    s_next.flush    = 1'b0;
    s_next.opt_load = 1'b0;
    s_next.wdt_clr  = 1'b0;
    s_next.psc_clr  = 1'b0;
    s_next.rdata    = 8'h00;

    // bus writes first, so the core below may override them
    if (bus.wr) begin
      case (bus.addr)
        `BCX_OFF_ACC: begin
          s_next.acc = bus.wdata;
        end
        `BCX_OFF_STATUS: begin
          s_next.carry = bus.wdata[`BCX_ST_CARRY];
          s_next.half  = bus.wdata[`BCX_ST_HALF];
          s_next.zero  = bus.wdata[`BCX_ST_ZERO];
          s_next.pd_n  = bus.wdata[`BCX_ST_PD_N];
          s_next.to_n  = bus.wdata[`BCX_ST_TO_N];
          s_next.wake  = bus.wdata[`BCX_ST_WAKE];
        end
        default: begin
          s_next.acc = s_next.acc;
        end
      endcase
    end

    // bus read data, valid only in the following cycle
    if (bus.rd) begin
      case (bus.addr)
        `BCX_OFF_ACC:    s_next.rdata = s_reg.acc;
        `BCX_OFF_STATUS: s_next.rdata = status_view;
        `BCX_OFF_OPTION: s_next.rdata = s_reg.opt;
        `BCX_OFF_CORE:   s_next.rdata = core_view;
        default:         s_next.rdata = 8'h00;
      endcase
    end

    case (s_reg.st)
      bcx_pkg::ST_IDLE: begin
        if (take) begin
          if (is_load_lit) begin
            s_next.acc = lit;
          end else if (is_opt_load) begin
            s_next.opt      = s_reg.acc;
            s_next.opt_load = 1'b1;
          end else if (is_ret_lit) begin
            s_next.acc     = lit;
            pc_next        = stack_top;
            s_next.pc_load = 1'b1;
            s_next.flush   = 1'b1;
            s_next.ready   = 1'b0;
            s_next.st      = bcx_pkg::ST_RET;
          end else if (is_sleep) begin
            s_next.wdt_clr  = 1'b1;
            s_next.psc_clr  = 1'b1;
            s_next.to_n     = 1'b1;
            s_next.pd_n     = 1'b0;
            s_next.wake     = s_reg.wake;
            s_next.osc_stop = 1'b1;
            s_next.ready    = 1'b0;
            s_next.st       = bcx_pkg::ST_SLEEP;
          end else if (is_sub || is_rot_left || is_rot_right) begin
            s_next.faddr     = faddr_in;
            s_next.dest_file = dest_in;
            s_next.ready     = 1'b0;
            s_next.st        = bcx_pkg::ST_FILE;
            if (is_sub) begin
              s_next.alu = bcx_pkg::ALU_SUB;
            end else if (is_rot_left) begin
              s_next.alu = bcx_pkg::ALU_RL;
            end else begin
              s_next.alu = bcx_pkg::ALU_RR;
            end
          end
        end
      end

      bcx_pkg::ST_FILE: begin
        // operand has arrived from storage, finish the operation
        if (s_reg.dest_file) begin
          fw_en_next   = 1'b1;
          fw_addr_next = s_reg.faddr;
          fw_data_next = res;
        end else begin
          s_next.acc = res;
        end
        s_next.carry = res_carry;
        if (s_reg.alu == bcx_pkg::ALU_SUB) begin
          s_next.half = sub_low[4];
          s_next.zero = (res == 8'h00);
        end
        s_next.ready = 1'b1;
        s_next.st    = bcx_pkg::ST_IDLE;
      end

      bcx_pkg::ST_RET: begin
        // second cycle of the return; fetch refills from the new pc
        s_next.ready = 1'b1;
        s_next.st    = bcx_pkg::ST_IDLE;
      end

      bcx_pkg::ST_SLEEP: begin
        // nothing executes until a wake source restarts the core
        if (wake_req) begin
          s_next.osc_stop = 1'b0;
          s_next.ready    = 1'b1;
          s_next.st       = bcx_pkg::ST_IDLE;
        end
      end

      default: begin
        s_next.ready = 1'b1;
        s_next.st    = bcx_pkg::ST_IDLE;
      end
    endcase

    // synchronous reset
    if (!rst_n) begin
      s_next       = '0;
      s_next.st    = bcx_pkg::ST_IDLE;
      s_next.alu   = bcx_pkg::ALU_SUB;
      s_next.acc   = `BCX_RST_ACC;
      s_next.opt   = `BCX_RST_OPTION;
      s_next.to_n  = 1'b1;
      s_next.pd_n  = 1'b1;
      s_next.ready = 1'b1;
      pc_next      = 11'h000;
      fw_en_next   = 1'b0;
      fw_addr_next = 5'h00;
      fw_data_next = 8'h00;
    end
  end

  // one register stage for all state
  always_ff @(posedge ref_clk) begin
    s_reg       <= s_next;
    pc_reg      <= pc_next;
    fw_en_reg   <= fw_en_next;
    fw_addr_reg <= fw_addr_next;
    fw_data_reg <= fw_data_next;
  end

  // outputs straight from flip-flops
  assign instr_ready          = s_reg.ready;
  assign pc_value             = pc_reg;
  assign pc_load              = s_reg.pc_load;
  assign fetch_flush          = s_reg.flush;
  assign option_value         = s_reg.opt;
  assign option_load          = s_reg.opt_load;
  assign watchdog_counter_clr = s_reg.wdt_clr;
  assign prescaler_clr        = s_reg.psc_clr;
  assign osc_stop             = s_reg.osc_stop;
  assign file_wr_en           = fw_en_reg;
  assign file_wr_addr         = fw_addr_reg;
  assign file_wr_data         = fw_data_reg;
  assign bus_rdata            = s_reg.rdata;

endmodule

// ### verilog/bcx_params.svh
`ifndef BCX_PARAMS_SVH
`define BCX_PARAMS_SVH

// instruction word geometry
`define BCX_IW             12
`define BCX_LIT_MSB        7
`define BCX_DEST_BIT       5
`define BCX_FADDR_MSB      4

// opcode patterns and the masks that select their fixed bits
`define BCX_MASK_LIT       12'hf00
`define BCX_MASK_FILE      12'hfc0
`define BCX_MASK_FULL      12'hfff
`define BCX_ENC_LOAD_LIT   12'hc00
`define BCX_ENC_RET_LIT    12'h800
`define BCX_ENC_OPT_LOAD   12'h002
`define BCX_ENC_SLEEP      12'h003
`define BCX_ENC_SUB        12'h080
`define BCX_ENC_ROT_RIGHT  12'h300
`define BCX_ENC_ROT_LEFT   12'h340

// register bus map, word offsets on a 6-bit address
`define BCX_AW             6
`define BCX_OFF_ACC        6'h00
`define BCX_OFF_STATUS     6'h01
`define BCX_OFF_OPTION     6'h02
`define BCX_OFF_CORE       6'h03
`define BCX_OFF_FILE_BASE  6'h20

// status field positions
`define BCX_ST_CARRY       0
`define BCX_ST_HALF        1
`define BCX_ST_ZERO        2
`define BCX_ST_PD_N        3
`define BCX_ST_TO_N        4
`define BCX_ST_WAKE        7

// reset values
`define BCX_RST_ACC        8'h00
`define BCX_RST_OPTION     8'hff

`endif

// ### verilog/bcx_pkg.sv
package bcx_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FILE  = 2'b01,
    ST_RET   = 2'b10,
    ST_SLEEP = 2'b11
  } bcx_state_t;

  // file-register operations finished in the second cycle
  typedef enum logic [1:0] {
    ALU_SUB = 2'b00,
    ALU_RL  = 2'b01,
    ALU_RR  = 2'b10
  } bcx_alu_t;

  // instruction from fetch
  typedef struct packed {
    logic        valid;
    logic [11:0] word;
  } bcx_instr_t;

  // register bus request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bcx_bus_t;

  // all state of the core except the pc and the file write mirror
  typedef struct packed {
    bcx_state_t st;
    bcx_alu_t   alu;
    logic [7:0] acc;
    logic [7:0] opt;
    logic       carry;
    logic       half;
    logic       zero;
    logic       to_n;
    logic       pd_n;
    logic       wake;
    logic       dest_file;
    logic [4:0] faddr;
    logic       ready;
    logic       pc_load;
    logic       flush;
    logic       opt_load;
    logic       wdt_clr;
    logic       psc_clr;
    logic       osc_stop;
    logic [7:0] rdata;
  } bcx_core_t;

endpackage

// ### verilog/bcx_file_mem.sv
module bcx_file_mem #(
  parameter int W = 8,
  parameter int D = 32,
  parameter int A = 5
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // write port
  input  wire logic         wr_en,
  input  wire logic [A-1:0] wr_addr,
  input  wire logic [W-1:0] wr_data,
  // read port, data registered
  input  wire logic [A-1:0] rd_addr,
  output logic      [W-1:0] rd_data
);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0]        rd;
  } bcx_mem_t;

  bcx_mem_t m_reg;
  bcx_mem_t m_next;

  // read sees the old word when read and write hit the same entry
  always_comb begin
    m_next = m_reg;
    m_next.rd = m_reg.mem[rd_addr];
    if (wr_en) begin
      m_next.mem[wr_addr] = wr_data;
    end
    if (!rst_n) begin
      m_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    m_reg <= m_next;
  end

  assign rd_data = m_reg.rd;

endmodule

// ### tb/bcx_monitor.sv
module bcx_monitor (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // core ports under watch
  input wire bcx_pkg::bcx_instr_t instr,
  input wire logic                instr_ready,
  input wire logic [10:0]         stack_top,
  input wire logic [10:0]         pc_value,
  input wire logic                pc_load,
  input wire logic                fetch_flush,
  input wire logic                option_load,
  input wire logic                watchdog_counter_clr,
  input wire logic                prescaler_clr,
  input wire logic                osc_stop,
  input wire logic                wake_req,
  input wire logic                file_wr_en,
  input wire logic [4:0]          file_wr_addr,
  input wire bcx_pkg::bcx_bus_t   bus,
  input wire logic [7:0]          bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // decoded view of the word taken this cycle
  wire        tk = instr.valid && instr_ready;
  wire [11:0] wm = instr.word & 12'hfc0;
  wire        dbit = instr.word[5];
  wire [4:0]  fa = instr.word[4:0];
  wire        brd = bus.rd;
  wire        ret = tk && (instr.word & 12'hf00) == 12'h800;
  wire        slp = tk && instr.word == 12'h003;
  wire        fop = tk && (wm == 12'h080 || wm == 12'h300 || wm == 12'h340);
  // two-cycle ops stall exactly one cycle
  sequence two_cyc;
    !instr_ready ##1 instr_ready;
  endsequence
  opt_pulse_a: assert property (tk && instr.word == 12'h002 |=> option_load)
    else $error("option load pulse missing");
  ret_pc_a: assert property (ret |=> pc_load && pc_value == $past(stack_top))
    else $error("return did not load pc");
  ret_cycles_a: assert property (ret |=> fetch_flush ##0 two_cyc)
    else $error("return cycle count wrong");
  flush_pair_a: assert property (pc_load == fetch_flush)
    else $error("flush not paired with pc load");
  sleep_clr_a: assert property (slp |=> watchdog_counter_clr && prescaler_clr)
    else $error("sleep did not clear watchdog");
  sleep_stop_a: assert property (slp |=> osc_stop && !instr_ready)
    else $error("sleep did not halt");
  sleep_hold_a: assert property (osc_stop && !wake_req |=> osc_stop && !instr_ready)
    else $error("left sleep without wake");
  file_dest_a: assert property (fop |=> two_cyc ##0 file_wr_en == $past(dbit, 2))
    else $error("destination select wrong");
  file_addr_a: assert property (file_wr_en |-> file_wr_addr == $past(fa, 2))
    else $error("file write address wrong");
  rdata_idle_a: assert property (!$past(brd) |-> bus_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

bind bcx_core bcx_monitor u_bcx_monitor (
  .ref_clk, .rst_n, .instr, .instr_ready, .stack_top, .pc_value, .pc_load,
  .fetch_flush, .option_load, .watchdog_counter_clr, .prescaler_clr, .osc_stop,
  .wake_req, .file_wr_en, .file_wr_addr, .bus, .bus_rdata
);

// ### tb/tb_top.sv
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk, rst_n, wake_req, rdy, pc_load, flush, opt_ld;
  logic                wdc, psc, osc_stop, fw_en, cap_en;
  logic [10:0]         stack_top, pc_value;
  logic [7:0]          opt_val, bus_rdata, fw_data, cap_data;
  logic [4:0]          fw_addr, cap_addr, cap_n;
  logic [2:0]          cap_pls;
  bcx_pkg::bcx_instr_t instr;
  bcx_pkg::bcx_bus_t   bus;
  int                  err_total, check_count;

  bcx_core u_bcx_core (
    .ref_clk, .rst_n, .instr, .instr_ready(rdy), .stack_top, .pc_value, .pc_load,
    .fetch_flush(flush), .option_value(opt_val), .option_load(opt_ld),
    .watchdog_counter_clr(wdc), .prescaler_clr(psc), .osc_stop, .wake_req,
    .file_wr_en(fw_en), .file_wr_addr(fw_addr), .file_wr_data(fw_data),
    .bus, .bus_rdata
  );

  // free running 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bus tasks idle a cycle after the strobe so no signal is set twice per step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    @(negedge ref_clk);
    `CK(bus_rdata, e)
    @(posedge ref_clk);
  endtask

  // issue one word, wait bounded for ready, keep the mirror seen then
  task automatic ex(input logic [11:0] w);
    int n;
    instr <= {1'b1, w};
    @(posedge ref_clk);
    instr <= '0;
    @(negedge ref_clk);
    cap_pls = {pc_load, flush, opt_ld};
    n = 0;
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    `CK(rdy, 1'b1)
    cap_en = fw_en;
    cap_addr = fw_addr;
    cap_data = fw_data;
    cap_n = 5'(n);
    @(posedge ref_clk);
  endtask

  task automatic t_reset;
    `CK(opt_val, 8'hff)
    rd(6'h00, 8'h00);
    rd(6'h01, 8'h18);
    rd(6'h10, 8'h00);
    rd(6'h03, 8'h00);
    wr(6'h02, 8'h12);
    rd(6'h02, 8'hff);
  endtask

  task automatic t_lit(input logic [7:0] k);
    wr(6'h01, 8'h07);
    ex({4'hc, k});
    `CK({cap_pls, cap_n}, 8'h00)
    rd(6'h00, k);
    rd(6'h01, 8'h07);
  endtask

  task automatic t_opt;
    wr(6'h00, 8'h3c);
    wr(6'h01, 8'h05);
    ex(12'h002);
    `CK({cap_pls, cap_n}, 8'h20)
    `CK(opt_val, 8'h3c)
    rd(6'h01, 8'h05);
  endtask

  task automatic t_ret;
    wr(6'h01, 8'h1a);
    stack_top <= 11'h5a5;
    ex(12'h896);
    `CK({cap_pls, cap_n}, 8'hc1)
    `CK(pc_value, 11'h5a5)
    rd(6'h00, 8'h96);
    rd(6'h01, 8'h1a);
  endtask

  // wake flag and carry must survive sleep; timeout bit starts low on purpose
  task automatic t_sleep;
    int n;
    wr(6'h01, 8'h89);
    instr <= {1'b1, 12'h003};
    @(posedge ref_clk);
    instr <= '0;
    @(negedge ref_clk);
    `CK({wdc, psc, osc_stop, rdy}, 4'b1110)
    repeat (4) @(negedge ref_clk);
    `CK({wdc, psc, osc_stop, rdy}, 4'b0010)
    @(posedge ref_clk);
    rd(6'h03, 8'h07);
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    @(negedge ref_clk);
    n = 0;
    while (rdy !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    `CK({osc_stop, rdy}, 2'b01)
    @(posedge ref_clk);
    rd(6'h01, 8'h91);
  endtask

  // file ops: load operand, acc and flags, run, judge result and flags
  task automatic t_file(input logic [11:0] w, input logic [7:0] fv, av, s0, r, s1);
    wr({1'b1, w[4:0]}, fv);
    wr(6'h00, av);
    wr(6'h01, s0);
    ex(w);
    `CK({cap_pls, cap_n}, 8'h01)
    if (w[5]) begin
      `CK({cap_en, cap_addr, cap_data}, {1'b1, w[4:0], r})
      rd(6'h00, av);
    end else begin
      `CK(cap_en, 1'b0)
      rd(6'h00, r);
    end
    rd(6'h01, s1);
  endtask

  initial begin
    rst_n = 1'b0;
    wake_req = 1'b0;
    stack_top = '0;
    instr = '0;
    bus = '0;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_lit(8'h00);
    t_lit(8'hff);
    t_lit(8'ha5);
    t_opt;
    t_ret;
    t_sleep;
    t_file(12'h0a3, 8'h50, 8'h20, 8'h18, 8'h30, 8'h1b);
    t_file(12'h09f, 8'h10, 8'h01, 8'h18, 8'h0f, 8'h19);
    t_file(12'h0a0, 8'h05, 8'h05, 8'h18, 8'h00, 8'h1f);
    t_file(12'h087, 8'h00, 8'h01, 8'h1f, 8'hff, 8'h18);
    t_file(12'h369, 8'h81, 8'h00, 8'h1c, 8'h02, 8'h1d);
    t_file(12'h342, 8'h40, 8'h00, 8'h1f, 8'h81, 8'h1e);
    t_file(12'h324, 8'h01, 8'h00, 8'h18, 8'h00, 8'h19);
    t_file(12'h31e, 8'h80, 8'h00, 8'h1b, 8'hc0, 8'h1a);
    conclude;
  end

  // hang guard, well past the fewer than 200 cycles the run needs
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
